// *** verilog/mvd_top.sv ***
// Magnetic vector-magnitude change detector with AXI4-Lite register slave
// Notes on behaviour
// - Latched flag held until source register read
// - Unlatched flag follows live detection result
// - Init mode 0: references from current sample
// - Init mode 1: references from initial registers
// - Update mode 0: event reloads references
// - Update mode 1: event keeps references
// - Both modes 1: initial writes track live
// - Enable starts detection and loads references
// - Wake enable includes flag in auto-sleep
// - Interrupt enable gates the pin output
// - Routing bit: 0 pin two, 1 pin one
// - Debounce mode 0: decrement when below
// - Debounce mode 1: clear when below
// - Threshold is 15-bit unsigned, split registers
// - Debounce count is eight bits, per sample
// - Hybrid operation halves the effective rate
// - Initial references signed 16-bit, byte pairs
// - Event when distance exceeds threshold long enough
// - References never readable by the host
// - Flag reads one after event, else zero
`timescale 1ns/1ns

module mvd_top (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   mag_valid,
  input  wire mvd_pkg::mvd_sample_t   mag_data,
  input  wire logic [mvd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [mvd_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        irq_pin_one,
  output logic                        irq_pin_two,
  output logic                        wake_activity
);

  // True for the address of a mapped register, false for no match
  function automatic logic reg_known(input logic [mvd_pkg::ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[mvd_pkg::IDX_MSB:mvd_pkg::IDX_LSB];
    reg_known = 1'b0;
    if (addr[mvd_pkg::ADDR_W-1:mvd_pkg::IDX_MSB+1] != '0) begin
      reg_known = 1'b0;
    end else if (idx == mvd_pkg::IDX_INT_SOURCE) begin
      reg_known = 1'b1;
    end else if (idx >= mvd_pkg::IDX_CONFIG && idx <= mvd_pkg::IDX_MODE) begin
      reg_known = 1'b1;
    end
  endfunction : reg_known

  // Registers
  mvd_pkg::mvd_cfg_t   cfg_r;
  logic [7:0]          ths_high_r;
  logic [7:0]          ths_low_r;
  logic [7:0]          deb_count_r;
  mvd_pkg::mvd_sample_t init_r;
  logic [7:0]          mode_r;

  // Detector state
  mvd_pkg::mvd_sample_t ref_r;
  mvd_pkg::mvd_sample_t last_r;
  logic [7:0]          deb_cnt_r;
  logic [7:0]          deb_cnt_nxt;
  logic                live_r;
  logic                latch_r;
  logic                phase_r;
  logic                en_d_r;

  // Bus state
  logic                        aw_got_r;
  logic                        w_got_r;
  logic [mvd_pkg::ADDR_W-1:0]  aw_addr_r;
  logic [31:0]                 w_data_r;
  logic [3:0]                  w_strb_r;

  logic                        aw_hs;
  logic                        w_hs;
  logic                        ar_hs;
  logic                        wr_fire;
  logic [mvd_pkg::ADDR_W-1:0]  wr_addr;
  logic [31:0]                 wr_data;
  logic [3:0]                  wr_strb;
  logic [7:0]                  wr_idx;
  logic                        wr_en;
  logic [7:0]                  rd_byte;
  logic [7:0]                  rd_idx;
  logic                        src_read;

  // Arithmetic
  logic signed [33:0]  dx;
  logic signed [33:0]  dy;
  logic signed [33:0]  dz;
  logic [35:0]         dist_sq;
  logic [29:0]         ths_sq;
  logic [14:0]         ths;
  logic                above;
  logic                sample_tick;
  logic                trigger;
  logic                en_rise;
  logic                flag;

  // ---------------- AXI4-Lite write path ----------------
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign wr_fire       = (aw_got_r || aw_hs) && (w_got_r || w_hs);
  assign wr_addr       = aw_got_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data       = w_got_r ? w_data_r : s_axi_wdata;
  assign wr_strb       = w_got_r ? w_strb_r : s_axi_wstrb;
  assign wr_idx        = wr_addr[mvd_pkg::IDX_MSB:mvd_pkg::IDX_LSB];
  // Registers sit in byte lane 0; other lanes are ignored
  assign wr_en         = wr_fire && wr_strb[0] && reg_known(wr_addr);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end else begin
        if (aw_hs) begin
          aw_got_r  <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_hs) begin
          w_got_r  <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mvd_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_known(wr_addr) ? mvd_pkg::RESP_OKAY : mvd_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- Register file ----------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_r       <= mvd_pkg::RST_BYTE;
      ths_high_r  <= mvd_pkg::RST_BYTE;
      ths_low_r   <= mvd_pkg::RST_BYTE;
      deb_count_r <= mvd_pkg::RST_BYTE;
      mode_r      <= mvd_pkg::RST_BYTE;
    end else if (wr_en) begin
      if (wr_idx == mvd_pkg::IDX_CONFIG) begin
        cfg_r <= wr_data[7:0];
      end else if (wr_idx == mvd_pkg::IDX_THS_HIGH) begin
        ths_high_r <= wr_data[7:0];
      end else if (wr_idx == mvd_pkg::IDX_THS_LOW) begin
        ths_low_r <= wr_data[7:0];
      end else if (wr_idx == mvd_pkg::IDX_DEB_COUNT) begin
        deb_count_r <= wr_data[7:0];
      end else if (wr_idx == mvd_pkg::IDX_MODE) begin
        mode_r <= wr_data[7:0];
      end
    end
  end

  // Initial references as signed byte pairs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      init_r <= {3{mvd_pkg::RST_WORD}};
    end else if (wr_en) begin
      if (wr_idx == mvd_pkg::IDX_INIT_X_HIGH) begin
        init_r.x[15:8] <= wr_data[7:0];
      end else if (wr_idx == mvd_pkg::IDX_INIT_X_LOW) begin
        init_r.x[7:0] <= wr_data[7:0];
      end else if (wr_idx == mvd_pkg::IDX_INIT_Y_HIGH) begin
        init_r.y[15:8] <= wr_data[7:0];
      end else if (wr_idx == mvd_pkg::IDX_INIT_Y_LOW) begin
        init_r.y[7:0] <= wr_data[7:0];
      end else if (wr_idx == mvd_pkg::IDX_INIT_Z_HIGH) begin
        init_r.z[15:8] <= wr_data[7:0];
      end else if (wr_idx == mvd_pkg::IDX_INIT_Z_LOW) begin
        init_r.z[7:0] <= wr_data[7:0];
      end
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = s_axi_araddr[mvd_pkg::IDX_MSB:mvd_pkg::IDX_LSB];
  assign src_read      = ar_hs && reg_known(s_axi_araddr) && rd_idx == mvd_pkg::IDX_INT_SOURCE;

  // References are kept out of the read map on purpose
  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx == mvd_pkg::IDX_INT_SOURCE) begin
      rd_byte[mvd_pkg::FLAG_BIT] = flag;
    end else if (rd_idx == mvd_pkg::IDX_CONFIG) begin
      rd_byte = cfg_r;
    end else if (rd_idx == mvd_pkg::IDX_THS_HIGH) begin
      rd_byte = ths_high_r;
    end else if (rd_idx == mvd_pkg::IDX_THS_LOW) begin
      rd_byte = ths_low_r;
    end else if (rd_idx == mvd_pkg::IDX_DEB_COUNT) begin
      rd_byte = deb_count_r;
    end else if (rd_idx == mvd_pkg::IDX_INIT_X_HIGH) begin
      rd_byte = init_r.x[15:8];
    end else if (rd_idx == mvd_pkg::IDX_INIT_X_LOW) begin
      rd_byte = init_r.x[7:0];
    end else if (rd_idx == mvd_pkg::IDX_INIT_Y_HIGH) begin
      rd_byte = init_r.y[15:8];
    end else if (rd_idx == mvd_pkg::IDX_INIT_Y_LOW) begin
      rd_byte = init_r.y[7:0];
    end else if (rd_idx == mvd_pkg::IDX_INIT_Z_HIGH) begin
      rd_byte = init_r.z[15:8];
    end else if (rd_idx == mvd_pkg::IDX_INIT_Z_LOW) begin
      rd_byte = init_r.z[7:0];
    end else if (rd_idx == mvd_pkg::IDX_MODE) begin
      rd_byte = mode_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= mvd_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      if (reg_known(s_axi_araddr)) begin
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= mvd_pkg::RESP_OKAY;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= mvd_pkg::RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- Detector ----------------
  // Hybrid operation interleaves both sensors, so only every other sample counts
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_r <= 1'b0;
    end else if (mag_valid) begin
      phase_r <= !phase_r;
    end
  end
  assign sample_tick = mag_valid && (!mode_r[mvd_pkg::HYBRID_BIT] || phase_r);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      last_r <= {3{mvd_pkg::RST_WORD}};
    end else if (mag_valid) begin
      last_r <= mag_data;
    end
  end

  // Distance squared against threshold squared avoids a square root
  // Differences kept at product width so the squares cannot wrap
  assign dx      = 34'(mag_data.x) - 34'(ref_r.x);
  assign dy      = 34'(mag_data.y) - 34'(ref_r.y);
  assign dz      = 34'(mag_data.z) - 34'(ref_r.z);
  assign dist_sq = 36'(dx * dx) + 36'(dy * dy) + 36'(dz * dz);
  assign ths     = {ths_high_r[6:0], ths_low_r};
  assign ths_sq  = 30'(ths) * 30'(ths);
  assign above   = dist_sq > 36'(ths_sq);

  // Event once the counter has reached the programmed count
  assign trigger = cfg_r.en && sample_tick && above && deb_cnt_r >= deb_count_r;

  always_comb begin
    deb_cnt_nxt = deb_cnt_r;
    if (!cfg_r.en) begin
      deb_cnt_nxt = 8'h00;
    end else if (sample_tick) begin
      if (above) begin
        if (trigger) begin
          deb_cnt_nxt = 8'h00;
        end else begin
          deb_cnt_nxt = deb_cnt_r + 8'h01;
        end
      end else if (ths_high_r[mvd_pkg::DBMODE_BIT]) begin
        deb_cnt_nxt = 8'h00;
      end else if (deb_cnt_r != 8'h00) begin
        deb_cnt_nxt = deb_cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      deb_cnt_r <= 8'h00;
    end else begin
      deb_cnt_r <= deb_cnt_nxt;
    end
  end

  assign en_rise = cfg_r.en && !en_d_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= cfg_r.en;
    end
  end

  // Reference loading; enable edge has priority over an event reload
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ref_r <= {3{mvd_pkg::RST_WORD}};
    end else if (en_rise) begin
      if (cfg_r.initm) begin
        ref_r <= init_r;
      end else begin
        ref_r <= last_r;
      end
    end else if (cfg_r.en && cfg_r.initm && cfg_r.updm) begin
      ref_r <= init_r;
    end else if (trigger && !cfg_r.updm) begin
      ref_r <= mag_data;
    end
  end

  // Live result stands until the next counted sample
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      live_r <= 1'b0;
    end else if (!cfg_r.en) begin
      live_r <= 1'b0;
    end else if (sample_tick) begin
      live_r <= trigger;
    end
  end

  // Set wins over the clear by a read in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latch_r <= 1'b0;
    end else if (trigger) begin
      latch_r <= 1'b1;
    end else if (src_read) begin
      latch_r <= 1'b0;
    end
  end

  assign flag = cfg_r.ele ? latch_r : live_r;

  // ---------------- Outputs ----------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_pin_one   <= 1'b0;
      irq_pin_two   <= 1'b0;
      wake_activity <= 1'b0;
    end else begin
      irq_pin_one   <= flag && cfg_r.int_en && cfg_r.int_cfg;
      irq_pin_two   <= flag && cfg_r.int_en && !cfg_r.int_cfg;
      wake_activity <= flag && cfg_r.wake_en;
    end
  end

endmodule : mvd_top

// *** verilog/mvd_pkg.sv ***
// Constants and types of the magnetic vector-magnitude change detector
package mvd_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_INT_SOURCE  = 8'h5e;
  localparam logic [7:0] IDX_CONFIG      = 8'h69;
  localparam logic [7:0] IDX_THS_HIGH    = 8'h6a;
  localparam logic [7:0] IDX_THS_LOW     = 8'h6b;
  localparam logic [7:0] IDX_DEB_COUNT   = 8'h6c;
  localparam logic [7:0] IDX_INIT_X_HIGH = 8'h6d;
  localparam logic [7:0] IDX_INIT_X_LOW  = 8'h6e;
  localparam logic [7:0] IDX_INIT_Y_HIGH = 8'h6f;
  localparam logic [7:0] IDX_INIT_Y_LOW  = 8'h70;
  localparam logic [7:0] IDX_INIT_Z_HIGH = 8'h71;
  localparam logic [7:0] IDX_INIT_Z_LOW  = 8'h72;
  localparam logic [7:0] IDX_MODE        = 8'h73;

  // Address layout
  localparam int         ADDR_W      = 12;
  localparam int         IDX_LSB     = 2;
  localparam int         IDX_MSB     = 9;

  // Field positions
  localparam int         FLAG_BIT    = 1;
  localparam int         DBMODE_BIT  = 7;
  localparam int         HYBRID_BIT  = 0;

  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Configuration byte, bit 7 down to bit 0
  typedef struct packed {
    logic rsvd;
    logic ele;
    logic initm;
    logic updm;
    logic en;
    logic wake_en;
    logic int_en;
    logic int_cfg;
  } mvd_cfg_t;

  // One decimated magnetic sample
  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } mvd_sample_t;

endpackage : mvd_pkg

// *** verification/mvd_checker.sv ***
// Port-level assertions for the vector-magnitude detector
`timescale 1ns/1ns
module mvd_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        mag_valid,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq_pin_one,
  input wire logic        irq_pin_two,
  input wire logic        wake_activity
);
  // Anything that may legally raise the flag or move the routing
  logic cause;
  assign cause = mag_valid || (s_axi_wvalid && s_axi_wready);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response missing");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during response");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open during response");
  chk_pin_onehot: assert property (!(irq_pin_one && irq_pin_two))
    else $error("both interrupt pins high");
  chk_irq_cause: assert property ($rose(irq_pin_one || irq_pin_two) |-> $past(cause, 2))
    else $error("interrupt rose without cause");
  chk_wake_cause: assert property ($rose(wake_activity) |-> $past(cause, 2))
    else $error("wake rose without cause");
endmodule : mvd_checker

bind mvd_top mvd_checker i_mvd_checker (.*);

// *** verification/tb_top.sv ***
// Self-checking bench for the vector-magnitude detector
`timescale 1ns/1ns
module tb_top;
  logic ref_clk, reset, mag_valid, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic irq_pin_one, irq_pin_two, wake_activity, dbm, hyb, ab, ev;
  logic [11:0]          s_axi_awaddr, s_axi_araddr;
  logic [31:0]          s_axi_wdata, s_axi_rdata, rs;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic [7:0]           b, cf;
  logic [13:0]          ths;
  logic [2:0]           cnt;
  mvd_pkg::mvd_sample_t mag_data;
  int                   error_cnt, n_compared, np, c;

  mvd_top i_mvd_top (.*);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
    @(posedge ref_clk);
    rs = lfsr(rs);
    s_axi_awaddr  <= {2'h0, i, 2'h0};
    s_axi_wdata   <= {rs[31:8], d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    s_axi_bready <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rdc(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
    @(posedge ref_clk);
    rs = lfsr(rs);
    s_axi_araddr  <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    s_axi_rready <= 1'b0;
    cmp("rdata", {24'h0, e}, s_axi_rdata);
    cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rdc

  task automatic smp(input logic signed [15:0] x, input logic signed [15:0] y,
                     input logic signed [15:0] z);
    @(posedge ref_clk);
    // Sparse pulses stand in for a slow output data rate
    mag_valid <= 1'b1;
    mag_data  <= {x, y, z};
    np++;
    @(posedge ref_clk);
    mag_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : smp

  task automatic pins(input logic e1, input logic e2, input logic ew);
    @(posedge ref_clk);
    cmp("irq_pin_one", {31'h0, e1}, {31'h0, irq_pin_one});
    cmp("irq_pin_two", {31'h0, e2}, {31'h0, irq_pin_two});
    cmp("wake_activity", {31'h0, ew}, {31'h0, wake_activity});
  endtask : pins

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end

  initial begin
    rs = 32'h5905bd3e;
    {error_cnt, n_compared, np} = '0;
    {reset, mag_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    mag_data    = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 8'h69; i <= 8'h73; i++) rdc(i[7:0], 8'h00);
    rdc(mvd_pkg::IDX_INT_SOURCE, 8'h00);
    rdc(8'h10, 8'h00, mvd_pkg::RESP_DECERR);
    wr(8'h10, 8'hff, mvd_pkg::RESP_DECERR);
    for (int i = 8'h6a; i <= 8'h73; i++) begin
      rs = lfsr(rs);
      b  = rs[7:0];
      wr(i[7:0], b);
      rdc(i[7:0], b);
    end
    for (int i = 8'h6d; i <= 8'h72; i++) wr(i[7:0], 8'h00);
    // Random threshold, count, debounce mode and hybrid against a bench model
    for (int run = 0; run < 6; run++) begin
      wr(mvd_pkg::IDX_CONFIG, 8'h00);
      rs  = lfsr(rs);
      ths = rs[13:0];
      cnt = rs[17:15];
      dbm = rs[20];
      hyb = rs[21];
      wr(mvd_pkg::IDX_THS_HIGH, {dbm, 1'b0, ths[13:8]});
      wr(mvd_pkg::IDX_THS_LOW, ths[7:0]);
      wr(mvd_pkg::IDX_DEB_COUNT, {5'h0, cnt});
      wr(mvd_pkg::IDX_MODE, {7'h0, hyb});
      wr(mvd_pkg::IDX_CONFIG, 8'h3b);
      c  = 0;
      ev = 1'b0;
      repeat (24) begin
        rs = lfsr(rs);
        ab = rs[3];
        smp(16'sh0, 16'sh0, ab ? ths + 16'h1 : ths);
        if (!hyb || np % 2 == 0) begin
          ev = ab && c >= cnt;
          c  = ab ? (ev ? 0 : c + 1) : (dbm || c == 0) ? 0 : c - 1;
        end
        pins(ev, 1'b0, 1'b0);
      end
    end
    wr(mvd_pkg::IDX_THS_HIGH, 8'h00);
    wr(mvd_pkg::IDX_THS_LOW, 8'h64);
    wr(mvd_pkg::IDX_DEB_COUNT, 8'h00);
    wr(mvd_pkg::IDX_MODE, 8'h00);
    wr(mvd_pkg::IDX_CONFIG, 8'h00);
    // Events of the unlatched runs still sit in the latch; read clears it
    rdc(mvd_pkg::IDX_INT_SOURCE, 8'h00);
    wr(mvd_pkg::IDX_CONFIG, 8'h7f);
    smp(16'sd60, 16'sd80, 16'sd0);
    pins(1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 8; k++) begin
      cf = {5'h0f, k[2:0]};
      wr(mvd_pkg::IDX_CONFIG, cf);
      smp(16'sd0, 16'sd0, 16'sd200);
      smp(16'sd0, 16'sd0, 16'sd0);
      pins(cf[1] & cf[0], cf[1] & ~cf[0], cf[2]);
      rdc(mvd_pkg::IDX_INT_SOURCE, 8'h02);
      pins(1'b0, 1'b0, 1'b0);
    end
    wr(mvd_pkg::IDX_CONFIG, 8'h00);
    smp(16'sd1000, 16'sd0, 16'sd0);
    wr(mvd_pkg::IDX_CONFIG, 8'h1b);
    smp(16'sd1000, 16'sd0, 16'sd50);
    pins(1'b0, 1'b0, 1'b0);
    smp(16'sd0, 16'sd0, 16'sd0);
    pins(1'b1, 1'b0, 1'b0);
    smp(16'sd0, 16'sd0, 16'sd0);
    pins(1'b1, 1'b0, 1'b0);
    wr(mvd_pkg::IDX_CONFIG, 8'h0b);
    smp(16'sd0, 16'sd0, 16'sd0);
    pins(1'b1, 1'b0, 1'b0);
    smp(16'sd0, 16'sd0, 16'sd0);
    pins(1'b0, 1'b0, 1'b0);
    wr(mvd_pkg::IDX_CONFIG, 8'h00);
    wr(mvd_pkg::IDX_INIT_X_HIGH, 8'hfe);
    wr(mvd_pkg::IDX_INIT_X_LOW, 8'h0c);
    wr(mvd_pkg::IDX_CONFIG, 8'h2b);
    smp(-16'sd500, 16'sd0, 16'sd0);
    pins(1'b0, 1'b0, 1'b0);
    smp(16'sd0, 16'sd0, 16'sd0);
    pins(1'b1, 1'b0, 1'b0);
    wr(mvd_pkg::IDX_CONFIG, 8'h3b);
    wr(mvd_pkg::IDX_INIT_X_HIGH, 8'h03);
    wr(mvd_pkg::IDX_INIT_X_LOW, 8'he8);
    smp(16'sd1000, 16'sd0, 16'sd0);
    pins(1'b0, 1'b0, 1'b0);
    wr(mvd_pkg::IDX_CONFIG, 8'h33);
    smp(16'sd0, 16'sd0, 16'sd0);
    pins(1'b0, 1'b0, 1'b0);
    complete_run();
  end
endmodule : tb_top
